// *** design/rtctcm_pkg.sv ***
package rtctcm_pkg;

    // register addresses of the supervisory byte map
    localparam logic [14:0] ADDR_RAM_TOP = 15'h7FEF;
    localparam logic [14:0] ADDR_RSV_LO = 15'h7FF0;
    localparam logic [14:0] ADDR_HUND = 15'h7FF7;
    localparam logic [14:0] ADDR_CAL_CTRL = 15'h7FF8;
    localparam logic [14:0] ADDR_SEC = 15'h7FF9;
    localparam logic [14:0] ADDR_MIN = 15'h7FFA;
    localparam logic [14:0] ADDR_HOUR = 15'h7FFB;
    localparam logic [14:0] ADDR_WDAY = 15'h7FFC;
    localparam logic [14:0] ADDR_DATE = 15'h7FFD;
    localparam logic [14:0] ADDR_MONTH = 15'h7FFE;
    localparam logic [14:0] ADDR_YEAR = 15'h7FFF;

    // field positions
    localparam int CAL_SIGN_BIT = 5;
    localparam int CAL_SLEEP_BIT = 6;
    localparam int CAL_WCLK_BIT = 7;
    localparam int SEC_HALT_BIT = 7;
    localparam int WDAY_BLOW_BIT = 7;
    localparam int WDAY_FT_BIT = 6;
    localparam int WDAY_ARM_BIT = 5;
    localparam int WDAY_TAMP_BIT = 4;

    // reset values
    localparam logic [7:0] CAL_CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // oscillator chain counts
    localparam logic [15:0] SEC_OSC_CYCLES = 16'h8000;
    localparam logic [15:0] CAL_POS_ADJ = 16'h0100;
    localparam logic [15:0] CAL_NEG_ADJ = 16'h0080;
    localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3B;
    localparam logic [5:0] CAL_CYCLE_LAST = 6'h3F;
    localparam int FT_DIV_BITS = 6;

    // pin synchroniser lanes
    localparam int PIN_OSC = 0;
    localparam int PIN_TAMPER = 1;
    localparam int PIN_VCC = 2;
    localparam int PIN_BAT = 3;
    localparam int PIN_COUNT = 4;

    // register request from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic stop;
        logic [14:0] addr;
        logic [7:0] wdata;
    } rtctcm_regreq_type;

    // live time bytes from the clock counters
    typedef struct packed {
        logic [7:0] hund;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rtctcm_time_type;

    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_CHECK = 2'b01,
        PWR_ON = 2'b10
    } rtctcm_pwr_type;

endpackage

// *** design/rtctcm_sync.sv ***
`timescale 1ns/1ps

module rtctcm_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);

    // refuse an empty synchroniser
    if (WIDTH < 1) begin : g_width_check
        $error("rtctcm_sync width must be at least one");
    end

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;

    // three stages per lane, change taken once stage two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                s1_ff[i] <= 1'b0;
                s2_ff[i] <= 1'b0;
                s3_ff[i] <= 1'b0;
                level_ff[i] <= 1'b0;
            end else begin
                s1_ff[i] <= pin_async[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i]) begin
                    level_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign pin_level = level_ff;

endmodule

// *** design/rtctcm_top.sv ***
`timescale 1ns/1ps

module rtctcm_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire rtctcm_pkg::rtctcm_regreq_type reg_req,
    input wire rtctcm_pkg::rtctcm_time_type live_time,
    input wire logic osc_32k_pin,
    input wire logic tamper_input_pin,
    input wire logic vcc_ok_pin,
    input wire logic bat_ok_pin,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic sec_tick,
    output logic oscillator_halt,
    output logic write_clock,
    output logic sleep_arm,
    output logic freq_test_out,
    output logic freq_test_oe_n
);
    import rtctcm_pkg::*;

    logic [PIN_COUNT-1:0] pins_async;
    logic [PIN_COUNT-1:0] pins_s;
    logic osc_s;
    logic tamper_s;
    logic vcc_s;
    logic bat_s;

    logic osc_prev_ff;
    logic osc_tick;
    logic vcc_prev_ff;
    rtctcm_pwr_type pwr_ff;

    logic [7:0] cal_ctrl_ff;
    logic osc_halt_ff;
    logic tamper_arm_ff;
    logic freq_test_en_ff;
    logic tamper_flag_ff;
    logic battery_low_flag_ff;

    logic hold_ff;
    rtctcm_time_type user_time_ff;
    logic upd_en;

    logic [FT_DIV_BITS-1:0] ft_div_ff;
    logic freq_test_out_ff;
    logic freq_test_oe_n_ff;

    logic [15:0] sec_div_ff;
    logic [15:0] sec_len;
    logic [5:0] sec_in_min_ff;
    logic [5:0] cyc_min_ff;
    logic cal_active;
    logic sec_tick_ff;

    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [7:0] nxt_rdata;

    logic wr_cal;
    logic wr_sec;
    logic wr_wday;
    logic rd_clock;
    logic ram_access;
    logic arm_clear_wr;

    // all external pins through the three-stage synchroniser
    assign pins_async[PIN_OSC] = osc_32k_pin;
    assign pins_async[PIN_TAMPER] = tamper_input_pin;
    assign pins_async[PIN_VCC] = vcc_ok_pin;
    assign pins_async[PIN_BAT] = bat_ok_pin;

    rtctcm_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin_async(pins_async),
        .pin_level(pins_s)
    );

    assign osc_s = pins_s[PIN_OSC];
    assign tamper_s = pins_s[PIN_TAMPER];
    assign vcc_s = pins_s[PIN_VCC];
    assign bat_s = pins_s[PIN_BAT];

    // register access decode
    assign wr_cal = reg_req.wr && (reg_req.addr == ADDR_CAL_CTRL);
    assign wr_sec = reg_req.wr && (reg_req.addr == ADDR_SEC);
    assign wr_wday = reg_req.wr && (reg_req.addr == ADDR_WDAY);
    assign rd_clock = reg_req.rd && (reg_req.addr >= ADDR_SEC);
    assign ram_access = (reg_req.rd || reg_req.wr) && (reg_req.addr <= ADDR_RAM_TOP);
    assign arm_clear_wr = wr_wday && !reg_req.wdata[WDAY_ARM_BIT];

    // oscillator edge, gated off while halted
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_s;
        end
    end

    assign osc_tick = osc_s && !osc_prev_ff && !osc_halt_ff;

    // main supply state and battery check
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pwr_ff <= PWR_OFF;
            vcc_prev_ff <= 1'b0;
        end else begin
            vcc_prev_ff <= vcc_s;
            unique case (pwr_ff)
                PWR_OFF: begin
                    if (vcc_s) begin
                        pwr_ff <= PWR_CHECK;
                    end
                end
                PWR_CHECK: begin
                    pwr_ff <= vcc_s ? PWR_ON : PWR_OFF;
                end
                PWR_ON: begin
                    if (!vcc_s) begin
                        pwr_ff <= PWR_OFF;
                    end
                end
                default: begin
                    pwr_ff <= PWR_OFF;
                end
            endcase
        end
    end

    // battery-low flag, only touched by the power-up check
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            battery_low_flag_ff <= 1'b0;
        end else if (pwr_ff == PWR_CHECK && vcc_s) begin
            battery_low_flag_ff <= !bat_s;
        end
    end

    // calibration control byte, all bits writable
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cal_ctrl_ff <= CAL_CTRL_RST;
        end else if (wr_cal) begin
            cal_ctrl_ff <= reg_req.wdata;
        end
    end

    // oscillator halt in the seconds byte
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            osc_halt_ff <= 1'b0;
        end else if (wr_sec) begin
            osc_halt_ff <= reg_req.wdata[SEC_HALT_BIT];
        end
    end

    // tamper arm bit; zero after reset so a stale arm never freezes time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tamper_arm_ff <= 1'b0;
        end else if (wr_wday) begin
            tamper_arm_ff <= reg_req.wdata[WDAY_ARM_BIT];
        end
    end

    // freq test enable, dropped whenever main supply falls
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            freq_test_en_ff <= 1'b0;
        end else if (!vcc_s && vcc_prev_ff) begin
            freq_test_en_ff <= 1'b0;
        end else if (wr_wday) begin
            freq_test_en_ff <= reg_req.wdata[WDAY_FT_BIT];
        end
    end

    // tamper flag: set wins, not gated by supply state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tamper_flag_ff <= 1'b0;
        end else if (tamper_arm_ff && tamper_s) begin
            tamper_flag_ff <= 1'b1;
        end else if (!tamper_arm_ff && !tamper_s) begin
            tamper_flag_ff <= 1'b0;
        end
    end

    // read hold: clock read or tamper resume holds until stop or RAM access
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_ff <= 1'b0;
        end else if (reg_req.stop || ram_access) begin
            hold_ff <= 1'b0;
        end else if (rd_clock || (arm_clear_wr && tamper_flag_ff)) begin
            hold_ff <= 1'b1;
        end
    end

    assign upd_en = !tamper_flag_ff && !hold_ff && !(tamper_arm_ff && tamper_s);

    // user-visible time copy, frozen on tamper or read hold
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            user_time_ff <= '0;
        end else if (upd_en) begin
            user_time_ff <= live_time;
        end
    end

    // free 512 Hz divider straight off the oscillator, no calibration path
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ft_div_ff <= '0;
        end else if (osc_tick) begin
            ft_div_ff <= ft_div_ff + 1'b1;
        end
    end

    // open-drain freq test pin: enable low pulls the line low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            freq_test_out_ff <= 1'b0;
            freq_test_oe_n_ff <= 1'b1;
        end else begin
            freq_test_out_ff <= 1'b0;
            freq_test_oe_n_ff <= !(freq_test_en_ff && !osc_halt_ff && !ft_div_ff[FT_DIV_BITS-1]);
        end
    end

    // correction applies to the first second of the first 2N minutes
    assign cal_active = (sec_in_min_ff == 6'h00) && (cyc_min_ff < {cal_ctrl_ff[4:0], 1'b0});
    always_comb begin
        sec_len = SEC_OSC_CYCLES;
        if (cal_active) begin
            if (cal_ctrl_ff[CAL_SIGN_BIT]) begin
                sec_len = SEC_OSC_CYCLES - CAL_POS_ADJ;
            end else begin
                sec_len = SEC_OSC_CYCLES + CAL_NEG_ADJ;
            end
        end
    end

    // calibrated second divider and minute position in the 64-minute cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sec_div_ff <= '0;
            sec_in_min_ff <= '0;
            cyc_min_ff <= '0;
            sec_tick_ff <= 1'b0;
        end else begin
            sec_tick_ff <= 1'b0;
            if (osc_tick) begin
                if (sec_div_ff >= sec_len - 16'h0001) begin
                    sec_div_ff <= '0;
                    sec_tick_ff <= 1'b1;
                    if (sec_in_min_ff == SEC_PER_MIN_LAST) begin
                        sec_in_min_ff <= '0;
                        cyc_min_ff <= cyc_min_ff + 1'b1;
                    end else begin
                        sec_in_min_ff <= sec_in_min_ff + 1'b1;
                    end
                end else begin
                    sec_div_ff <= sec_div_ff + 1'b1;
                end
            end
        end
    end

    // read data mux
    always_comb begin
        nxt_rdata = BYTE_RST;
        unique case (reg_req.addr)
            ADDR_HUND: nxt_rdata = user_time_ff.hund;
            ADDR_CAL_CTRL: nxt_rdata = cal_ctrl_ff;
            ADDR_SEC: nxt_rdata = {osc_halt_ff, user_time_ff.sec[6:0]};
            ADDR_MIN: nxt_rdata = user_time_ff.min;
            ADDR_HOUR: nxt_rdata = user_time_ff.hour;
            ADDR_WDAY: nxt_rdata = {battery_low_flag_ff, freq_test_en_ff, tamper_arm_ff,
                                    tamper_flag_ff, 1'b0, user_time_ff.wday[2:0]};
            ADDR_DATE: nxt_rdata = user_time_ff.date;
            ADDR_MONTH: nxt_rdata = user_time_ff.month;
            ADDR_YEAR: nxt_rdata = user_time_ff.year;
            default: nxt_rdata = BYTE_RST;
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= BYTE_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_req.rd;
            if (reg_req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign sec_tick = sec_tick_ff;
    assign oscillator_halt = osc_halt_ff;
    assign write_clock = cal_ctrl_ff[CAL_WCLK_BIT];
    assign sleep_arm = cal_ctrl_ff[CAL_SLEEP_BIT];
    assign freq_test_out = freq_test_out_ff;
    assign freq_test_oe_n = freq_test_oe_n_ff;

    default disable iff (!resetn);

    AST_TAMPER_SET: assert property (@(posedge clk_sys) tamper_arm_ff && tamper_s |=> tamper_flag_ff)
        else $error("tamper flag not set by armed pin");
    AST_NO_SET_DISARMED: assert property (@(posedge clk_sys)
        !tamper_flag_ff && !tamper_arm_ff |=> !tamper_flag_ff)
        else $error("tamper flag set while disarmed");
    AST_FLAG_STICKS: assert property (@(posedge clk_sys)
        tamper_flag_ff && (tamper_arm_ff || tamper_s) |=> tamper_flag_ff)
        else $error("tamper flag cleared too early");
    AST_FREEZE: assert property (@(posedge clk_sys) tamper_flag_ff |=> $stable(user_time_ff))
        else $error("time bytes moved while tamper flag set");
    AST_HOLD: assert property (@(posedge clk_sys)
        rd_clock ##1 (!reg_req.stop && !ram_access) [*2] |=> $stable(user_time_ff))
        else $error("time bytes moved during clock read hold");
    AST_CAL_WINDOW: assert property (@(posedge clk_sys)
        osc_tick && sec_len != SEC_OSC_CYCLES |-> sec_in_min_ff == 6'h00
        && cyc_min_ff < {cal_ctrl_ff[4:0], 1'b0})
        else $error("calibration outside the first 2N minutes");
    AST_FT_OFF: assert property (@(posedge clk_sys) !freq_test_en_ff || osc_halt_ff |=> freq_test_oe_n_ff)
        else $error("freq test pin driven while disabled");
    AST_FT_PWRDN: assert property (@(posedge clk_sys) !vcc_s && vcc_prev_ff |=> !freq_test_en_ff)
        else $error("freq test enable survived power-down");
    AST_BL_STABLE: assert property (@(posedge clk_sys) pwr_ff != PWR_CHECK |=> $stable(battery_low_flag_ff))
        else $error("battery low flag changed outside power-up check");
    AST_HALT: assert property (@(posedge clk_sys) osc_halt_ff |=> $stable(sec_div_ff) && $stable(ft_div_ff))
        else $error("oscillator chain ran while halted");

endmodule

// *** verif/rtctcm_host.sv ***
`timescale 1ns/1ps

module rtctcm_host (
    input wire logic clk_sys,
    output rtctcm_pkg::rtctcm_regreq_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    import rtctcm_pkg::*;

    // bus idle from time zero
    initial begin
        reg_req = '0;
    end

    // one-cycle write strobe
    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_req.addr <= addr;
        reg_req.wdata <= data;
        reg_req.wr <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask

    // one-cycle read strobe, answer awaited a few edges at most
    task automatic rd(input logic [14:0] addr, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge clk_sys);
        reg_req.addr <= addr;
        reg_req.rd <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk_sys);
            if (reg_rvalid === 1'b1) begin
                data = reg_rdata;
                ok = 1'b1;
            end
        end
    endtask

    // stop condition seen on the wire
    task automatic stop();
        @(posedge clk_sys);
        reg_req.stop <= 1'b1;
        @(posedge clk_sys);
        reg_req.stop <= 1'b0;
    endtask

    // disarm after first power or after the stamp was read
    task automatic disarm();
        wr(ADDR_WDAY, 8'h00);
    endtask

    // time is trusted only with the flag clear
    task automatic rd_now(input logic [14:0] addr, output logic [7:0] data, output logic ok);
        logic [7:0] stat;
        logic ok1;
        rd(ADDR_WDAY, stat, ok1);
        stop();
        rd(addr, data, ok);
        ok = ok & ok1 & (stat[WDAY_TAMP_BIT] === 1'b0);
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    import rtctcm_pkg::*;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd;
        logic [2:0] outs;
    } rtctcm_row_type;

    localparam int OSC_HALF = 3;
    logic clk_sys;
    logic resetn;
    rtctcm_regreq_type reg_req;
    rtctcm_time_type live_time;
    logic osc_32k_pin, tamper_input_pin, vcc_ok_pin, bat_ok_pin;
    logic [7:0] reg_rdata;
    logic reg_rvalid, sec_tick, oscillator_halt, write_clock, sleep_arm, freq_test_out, freq_test_oe_n;
    int mismatches, total_checks, osc_cnt, cyc;
    logic [7:0] rdv;
    logic ok;
    rtctcm_row_type rows [12];

    rtctcm_top rtctcm_top_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
        .live_time(live_time), .osc_32k_pin(osc_32k_pin), .tamper_input_pin(tamper_input_pin),
        .vcc_ok_pin(vcc_ok_pin), .bat_ok_pin(bat_ok_pin), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sec_tick(sec_tick), .oscillator_halt(oscillator_halt), .write_clock(write_clock),
        .sleep_arm(sleep_arm), .freq_test_out(freq_test_out), .freq_test_oe_n(freq_test_oe_n));

    rtctcm_host rtctcm_host_inst (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // system clock, 25 ns
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // fast stand-in for the crystal, six clocks a period
    always @(posedge clk_sys) begin
        osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == OSC_HALF - 1) begin
            osc_32k_pin <= ~osc_32k_pin;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic w(input logic [14:0] a, input logic [7:0] d);
        rtctcm_host_inst.wr(a, d);
    endtask

    task automatic st();
        rtctcm_host_inst.stop();
    endtask

    // read and compare; a lost answer ends the run
    task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
        rtctcm_host_inst.rd(a, rdv, ok);
        check({15'h0000, ok}, 16'h0001);
        if (ok !== 1'b1) begin
            end_of_test();
        end
        check({8'h00, rdv}, {8'h00, exp});
    endtask

    // cycles between the second and third edge of the test pin
    task automatic half_period(output int c);
        int edges;
        logic prev;
        edges = 0;
        c = 0;
        prev = freq_test_oe_n;
        for (int i = 0; i < 1500 && edges < 3; i++) begin
            @(posedge clk_sys);
            c++;
            if (freq_test_oe_n !== prev) begin
                prev = freq_test_oe_n;
                edges++;
                if (edges < 3) c = 0;
            end
        end
        if (edges < 3) begin
            check(16'h0000, 16'h0001);
            end_of_test();
        end
    endtask

    // test pin holds its level for 400 cycles
    task automatic steady(output logic s);
        logic lvl;
        lvl = freq_test_oe_n;
        s = 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            s = s & (freq_test_oe_n === lvl);
        end
    endtask

    initial begin
        resetn = 1'b0;
        live_time = '0;
        live_time.sec = 8'h23;
        live_time.wday = 8'h05;
        live_time.min = 8'h11;
        live_time.hund = 8'h42;
        osc_32k_pin = 1'b0;
        tamper_input_pin = 1'b0;
        vcc_ok_pin = 1'b1;
        bat_ok_pin = 1'b1;
        osc_cnt = 0;
        mismatches = 0;
        total_checks = 0;
        rows = '{'{ADDR_CAL_CTRL, 8'h25, 8'h25, 3'h0}, '{ADDR_CAL_CTRL, 8'h3F, 8'h3F, 3'h0},
            '{ADDR_CAL_CTRL, 8'hC0, 8'hC0, 3'h6}, '{ADDR_CAL_CTRL, 8'h00, 8'h00, 3'h0},
            '{15'h7FF3, 8'hAA, 8'h00, 3'h0}, '{15'h0100, 8'h55, 8'h00, 3'h0},
            '{ADDR_SEC, 8'h80, 8'hA3, 3'h1}, '{ADDR_SEC, 8'h00, 8'h23, 3'h0},
            '{ADDR_WDAY, 8'h80, 8'h05, 3'h0}, '{ADDR_WDAY, 8'h10, 8'h05, 3'h0},
            '{ADDR_WDAY, 8'h40, 8'h45, 3'h0}, '{ADDR_WDAY, 8'h00, 8'h05, 3'h0}};
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(2);
        check({1'b0, reg_rdata, reg_rvalid, sec_tick, oscillator_halt, write_clock, sleep_arm, freq_test_out,
            freq_test_oe_n}, 16'h0001);
        rtctcm_host_inst.disarm();
        // register rows: write, stop, read back, outputs
        foreach (rows[i]) begin
            w(rows[i].addr, rows[i].wdata);
            st();
            rdc(rows[i].addr, rows[i].rd);
            check({13'h0000, write_clock, sleep_arm, oscillator_halt}, {13'h0000, rows[i].outs});
            st();
        end
        $display("test registers done");
        // tamper: disarmed, armed, frozen stamp, release
        tamper_input_pin <= 1'b1;
        tick(8);
        rdc(ADDR_WDAY, 8'h05);
        tamper_input_pin <= 1'b0;
        tick(8);
        w(ADDR_WDAY, 8'h20);
        st();
        tamper_input_pin <= 1'b1;
        tick(8);
        live_time.min <= 8'h12;
        live_time.hund <= 8'h43;
        st();
        rdc(ADDR_WDAY, 8'h35);
        st();
        rdc(ADDR_MIN, 8'h11);
        rdc(ADDR_HUND, 8'h42);
        w(ADDR_WDAY, 8'h00);
        rdc(ADDR_WDAY, 8'h15);
        tamper_input_pin <= 1'b0;
        tick(8);
        rdc(ADDR_WDAY, 8'h05);
        rdc(ADDR_MIN, 8'h11);
        st();
        rdc(ADDR_MIN, 8'h12);
        live_time.min <= 8'h13;
        rdc(ADDR_MIN, 8'h12);
        rdc(15'h0000, 8'h00);
        rdc(ADDR_MIN, 8'h13);
        rtctcm_host_inst.rd_now(ADDR_HUND, rdv, ok);
        check({7'h00, ok, rdv}, 16'h0143);
        $display("test tamper done");
        // frequency test: rate, calibration, halt, disable
        w(ADDR_WDAY, 8'h40);
        half_period(cyc);
        check(cyc[15:0], 16'(64 * OSC_HALF));
        check({15'h0000, freq_test_out}, 16'h0000);
        w(ADDR_CAL_CTRL, 8'h3F);
        half_period(cyc);
        check(cyc[15:0], 16'(64 * OSC_HALF));
        w(ADDR_SEC, 8'h80);
        tick(8);
        steady(ok);
        check({15'h0000, ok}, 16'h0001);
        w(ADDR_SEC, 8'h00);
        w(ADDR_WDAY, 8'h00);
        tick(8);
        steady(ok);
        check({14'h0000, ok, freq_test_oe_n}, 16'h0003);
        st();
        $display("test freq done");
        // battery and power cycling
        w(ADDR_WDAY, 8'h60);
        bat_ok_pin <= 1'b0;
        tick(8);
        rdc(ADDR_WDAY, 8'h65);
        st();
        vcc_ok_pin <= 1'b0;
        tick(8);
        check({15'h0000, freq_test_oe_n}, 16'h0001);
        steady(ok);
        check({14'h0000, ok, freq_test_oe_n}, 16'h0003);
        tamper_input_pin <= 1'b1;
        tick(8);
        vcc_ok_pin <= 1'b1;
        tick(8);
        rdc(ADDR_WDAY, 8'hB5);
        bat_ok_pin <= 1'b1;
        tamper_input_pin <= 1'b0;
        tick(8);
        w(ADDR_WDAY, 8'h00);
        rdc(ADDR_WDAY, 8'h85);
        st();
        vcc_ok_pin <= 1'b0;
        tick(8);
        vcc_ok_pin <= 1'b1;
        tick(8);
        rdc(ADDR_WDAY, 8'h05);
        st();
        $display("test battery done");
        // reset in mid-run
        w(ADDR_CAL_CTRL, 8'hC5);
        w(ADDR_WDAY, 8'h60);
        @(posedge clk_sys);
        resetn <= 1'b0;
        tick(2);
        check({1'b0, reg_rdata, reg_rvalid, sec_tick, oscillator_halt, write_clock, sleep_arm, freq_test_out,
            freq_test_oe_n}, 16'h0001);
        resetn <= 1'b1;
        tick(2);
        rdc(ADDR_CAL_CTRL, 8'h00);
        rdc(ADDR_WDAY, 8'h05);
        $display("test reset done");
        end_of_test();
    end
endmodule
